// >>> verilog/uhk_pkg.sv
// package for the upconverter housekeeping control block
// assumes apb slave on pclk, one clock domain, all pins external to pclk
package uhk_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] CTRL0_ADDR     = 8'h00; // multiplier, lock monitor, cic clear
    localparam logic [7:0] CTRL1_ADDR     = 8'h04; // full sleep, auto powerdown
    localparam logic [7:0] STATUS_ADDR    = 8'h08; // housekeeping state
    localparam logic [7:0] PROF_BASE_ADDR = 8'h10; // profile n at base + n*16
    localparam logic [7:0] PROF_STRIDE    = 8'h10;
    localparam logic [7:0] PROF_FTW_OFS   = 8'h00;
    localparam logic [7:0] PROF_CFG_OFS   = 8'h04;

    // ==========================================================
    // control register 00h fields
    localparam int MULT_LSB      = 0;
    localparam int MULT_W        = 5;
    localparam int LOCKMON_BIT   = 5;
    localparam int CICCLR_BIT    = 7;
    localparam logic [7:0] CTRL0_RESET = 8'h24; // lock monitor bit set, multiplier 4
    // control register 01h fields
    localparam int AUTOPD_BIT    = 2;
    localparam int SLEEP_BIT     = 3;
    localparam logic [7:0] CTRL1_RESET = 8'h00;

    // multiplier codes
    localparam logic [4:0] MULT_BYPASS = 5'h01;
    localparam logic [4:0] MULT_MIN    = 5'h04;
    localparam logic [4:0] MULT_MAX    = 5'h14;

    // cic rate codes
    localparam logic [5:0] CIC_BYPASS  = 6'h01;

    // profile config word layout
    localparam int CFG_RATE_LSB  = 0;
    localparam int CFG_INVCIC_BIT = 6;
    localparam int CFG_SPINV_BIT = 7;
    localparam int CFG_SCALE_LSB = 8;

    // flush length: cycles per unit of interpolation and fixed tail
    localparam logic [15:0] FLUSH_PER_N = 16'h0064; // 8+12+72+5+margin
    localparam logic [15:0] FLUSH_TAIL  = 16'h0020;

    // sclk-domain carried profile
    typedef struct packed {
        logic [31:0] ftw;
        logic        spec_invert;
        logic        inv_cic_bypass;
        logic [5:0]  cic_rate;
        logic [7:0]  scale;
    } uhk_profile_s;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FLUSH = 2'b01,
        ST_HOLD  = 2'b10,
        ST_DOWN  = 2'b11
    } uhk_state_e;

endpackage

// >>> verilog/uhk_housekeeping.sv
// housekeeping control: profiles, pll setup, lock gating, data path flush, power-down
// assumes apb master on pclk; pins arrive asynchronous and are synchronised here
//
// What this block does
// - two select pins pick profile 0..3, high pin is bit one
// - each profile holds tuning word, invert, inverse cic bypass, cic rate, scale
// - select sampled on data clock in modulation and interpolation, else system clock
// - all-zero tuning word forces accumulator to zero, sine 0, cosine 1
// - five-bit multiplier in 00h; value 01h bypasses and powers down pll
// - values 04h..14h multiply reference; system clock must stay under 200 MHz
// - lock output follows pll lock whatever the monitor bit says
// - monitor clear and unlocked: hold accumulator, paths, cic, data clock, ignore gate
// - lock rising with monitor clear releases hold and runs the flush
// - monitor set (reset default): lock loss has no internal effect
// - differential select high takes differential reference, low single-ended
// - overflow output low normally, toggles with cic data on overflow
// - cic clear bit starts flush: ignore data, zero i/q, hold cic reset
// - cic clear bit self-clears when flush ends
// - flush time grows with interpolation rate
// - master reset held five reference cycles; flush runs after release
// - powerdown pin high runs flush before digital clocks stop
// - full sleep bit runs flush before analog sleep; pll enable drops as soon as the bit is set
// - in powerdown data clock keeps running, signal chain clocks stop
// - leaving powerdown needs no extra startup delay
// - full sleep is 01h bit 3, registers retained
// - cic rate 01h is bypass, 02h..3Fh interpolate by two to 63
`timescale 1ns/1ps

module uhk_housekeeping #(
    parameter int NPROF = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        profile_select_low,
    input  wire logic        profile_select_high,
    input  wire logic        pll_lock_in,
    input  wire logic        digital_powerdown_pin,
    input  wire logic        burst_transmit_gate,
    input  wire logic        differential_reference_select,
    input  wire logic        cic_overflow_event,
    input  wire logic        cic_msb_in,
    input  wire logic        parallel_data_clock_tick,
    input  wire logic        single_tone_mode,
    output logic             pll_lock_out,
    output logic             pll_enable,
    output logic      [4:0]  pll_multiplier,
    output logic             ref_diff_mode,
    output logic             interpolator_overflow_flag,
    output logic             parallel_data_clock_gate,
    output logic             accum_clear,
    output logic             iq_force_zero,
    output logic             cic_reset,
    output logic             data_ignore,
    output logic             tx_gate_out,
    output logic             chain_clock_enable,
    output logic             analog_sleep,
    output logic      [1:0]  active_profile,
    output uhk_pkg::uhk_profile_s profile_out
);

    // ==========================================================
    // pin synchronisers (two flops each, first read only by second)
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    wire  [NSYNC-1:0] pins_raw = {single_tone_mode, parallel_data_clock_tick, cic_msb_in, cic_overflow_event,
                                  burst_transmit_gate, digital_powerdown_pin,
                                  profile_select_high, profile_select_low};
    wire logic [NSYNC-1:0] lock_pins;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic lock_s1_reg;
    logic lock_s2_reg;
    logic lock_d_reg;
    // lock and differential select synchronised separately
    logic diff_s1_reg;
    logic diff_s2_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
            lock_d_reg  <= 1'b0;
            diff_s1_reg <= 1'b0;
            diff_s2_reg <= 1'b0;
        end
        else
        begin
            lock_s1_reg <= pll_lock_in;
            lock_s2_reg <= lock_s1_reg;
            lock_d_reg  <= lock_s2_reg;
            diff_s1_reg <= differential_reference_select;
            diff_s2_reg <= diff_s1_reg;
        end
    end
    assign lock_pins = sync2_reg;

    wire ps_lo     = lock_pins[0];
    wire ps_hi     = lock_pins[1];
    wire dpd_s     = lock_pins[2];
    wire gate_s    = lock_pins[3];
    wire ovf_s     = lock_pins[4];
    wire cmsb_s    = lock_pins[5];
    wire pdtick_s  = lock_pins[6];
    wire tone_s    = lock_pins[7];
    wire lock_rise = lock_s2_reg & ~lock_d_reg;

    // ==========================================================
    // registers
    logic [7:0]  ctrl0_reg;
    logic [7:0]  ctrl1_reg;
    logic [31:0] ftw_reg [NPROF];
    logic [15:0] cfg_reg [NPROF];

    wire apb_wr = psel & penable & pwrite;
    wire apb_rd = psel & ~penable & ~pwrite;
    wire [7:0] prof_ofs = paddr - uhk_pkg::PROF_BASE_ADDR;
    wire [1:0] prof_idx = prof_ofs[5:4];
    wire in_prof   = (paddr >= uhk_pkg::PROF_BASE_ADDR) && (prof_ofs < 8'(NPROF * 16));
    wire hit_ftw   = in_prof && (prof_ofs[3:0] == uhk_pkg::PROF_FTW_OFS[3:0]);
    wire hit_cfg   = in_prof && (prof_ofs[3:0] == uhk_pkg::PROF_CFG_OFS[3:0]);
    wire hit_ctrl0 = paddr == uhk_pkg::CTRL0_ADDR;
    wire hit_ctrl1 = paddr == uhk_pkg::CTRL1_ADDR;
    wire hit_stat  = paddr == uhk_pkg::STATUS_ADDR;
    wire mapped    = hit_ctrl0 | hit_ctrl1 | hit_stat | hit_ftw | hit_cfg;

    // flush control
    uhk_pkg::uhk_state_e state_reg;
    uhk_pkg::uhk_state_e state_next;
    logic [15:0] flush_cnt_reg;
    logic        flush_done;

    wire lockmon_off = ~ctrl0_reg[uhk_pkg::LOCKMON_BIT];
    wire unlocked_hold = lockmon_off & ~lock_s2_reg;
    wire sleep_req = ctrl1_reg[uhk_pkg::SLEEP_BIT] | dpd_s;
    wire clr_write = apb_wr & hit_ctrl0 & pwdata[uhk_pkg::CICCLR_BIT];
    wire start_flush = clr_write | (lockmon_off & lock_rise);

    // control register writes; cic clear bit set wins over self-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_reg <= uhk_pkg::CTRL0_RESET;
            ctrl1_reg <= uhk_pkg::CTRL1_RESET;
        end
        else
        begin
            if (apb_wr && hit_ctrl0)
                ctrl0_reg <= pwdata[7:0];
            else if (flush_done)
                ctrl0_reg[uhk_pkg::CICCLR_BIT] <= 1'b0;
            if (apb_wr && hit_ctrl1)
                ctrl1_reg <= pwdata[7:0];
        end
    end

    // profile storage; contents survive sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NPROF; i++)
            begin
                ftw_reg[i] <= '0;
                cfg_reg[i] <= 16'h0001;
            end
        end
        else if (apb_wr && hit_ftw)
            ftw_reg[prof_idx] <= pwdata;
        else if (apb_wr && hit_cfg)
            cfg_reg[prof_idx] <= pwdata[15:0];
    end

    // ==========================================================
    // profile selection: pins sampled on data clock tick or every cycle in tone mode
    logic [1:0] prof_sel_reg;
    wire  [1:0] pins_idx = {ps_hi, ps_lo};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prof_sel_reg <= 2'b00;
        else if (tone_s || pdtick_s)
            prof_sel_reg <= pins_idx;
    end

    wire [15:0] cur_cfg  = cfg_reg[prof_sel_reg];
    wire [5:0]  cur_rate = cur_cfg[uhk_pkg::CFG_RATE_LSB +: 6];
    // bypass and illegal 0 count as rate 1
    wire [5:0]  eff_rate = (cur_rate <= uhk_pkg::CIC_BYPASS) ? 6'h01 : cur_rate;
    // longest pipeline at this rate; keeps flush safe for both modes
    wire [15:0] flush_len = 16'(eff_rate * uhk_pkg::FLUSH_PER_N) + uhk_pkg::FLUSH_TAIL;

    // ==========================================================
    // flush state machine: reset release also starts a flush
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            uhk_pkg::ST_RUN:
                if (unlocked_hold)
                    state_next = uhk_pkg::ST_HOLD;
                else if (start_flush || sleep_req)
                    state_next = uhk_pkg::ST_FLUSH;
            uhk_pkg::ST_FLUSH:
                if (unlocked_hold)
                    state_next = uhk_pkg::ST_HOLD;
                else if (flush_done && !clr_write)
                    state_next = sleep_req ? uhk_pkg::ST_DOWN : uhk_pkg::ST_RUN;
            uhk_pkg::ST_HOLD:
                if (!unlocked_hold)
                    state_next = uhk_pkg::ST_FLUSH;
            uhk_pkg::ST_DOWN:
                if (unlocked_hold)
                    state_next = uhk_pkg::ST_HOLD;
                else if (start_flush || !sleep_req)
                    state_next = start_flush ? uhk_pkg::ST_FLUSH : uhk_pkg::ST_RUN;
            default:
                state_next = uhk_pkg::ST_RUN;
        endcase
    end

    assign flush_done = (state_reg == uhk_pkg::ST_FLUSH) && (flush_cnt_reg == 16'h0000);

    // counter loads on entry to flush or on a fresh clear request, counts down to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg     <= uhk_pkg::ST_FLUSH;
            flush_cnt_reg <= uhk_pkg::FLUSH_PER_N + uhk_pkg::FLUSH_TAIL;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next == uhk_pkg::ST_FLUSH && (state_reg != uhk_pkg::ST_FLUSH || clr_write))
                flush_cnt_reg <= flush_len;
            else if (state_reg == uhk_pkg::ST_FLUSH && flush_cnt_reg != 16'h0000)
                flush_cnt_reg <= flush_cnt_reg - 16'h0001;
        end
    end

    // ==========================================================
    // registered outputs
    wire in_flush = state_next == uhk_pkg::ST_FLUSH;
    wire in_hold  = state_next == uhk_pkg::ST_HOLD;
    wire in_down  = state_next == uhk_pkg::ST_DOWN;
    wire [4:0] mult = ctrl0_reg[uhk_pkg::MULT_LSB +: uhk_pkg::MULT_W];
    wire ftw_zero = ftw_reg[prof_sel_reg] == 32'h0000_0000;
    // overflow pin follows cic data rather than latching
    wire ovf_next = ovf_s & cmsb_s;
    wire [7:0] status_word = {ctrl0_reg[uhk_pkg::CICCLR_BIT], prof_sel_reg, lock_s2_reg,
                              state_reg, sleep_req, ovf_s};
    wire [31:0] rd_mux = hit_ctrl0 ? {24'h0, ctrl0_reg} :
                         hit_ctrl1 ? {24'h0, ctrl1_reg} :
                         hit_stat  ? {24'h0, status_word} :
                         hit_ftw   ? ftw_reg[prof_idx] :
                         hit_cfg   ? {16'h0, cfg_reg[prof_idx]} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_lock_out               <= 1'b0;
            pll_enable                 <= 1'b1;
            pll_multiplier             <= uhk_pkg::MULT_MIN;
            ref_diff_mode              <= 1'b0;
            interpolator_overflow_flag <= 1'b0;
            parallel_data_clock_gate   <= 1'b0;
            accum_clear                <= 1'b1;
            iq_force_zero              <= 1'b1;
            cic_reset                  <= 1'b1;
            data_ignore                <= 1'b1;
            tx_gate_out                <= 1'b0;
            chain_clock_enable         <= 1'b1;
            analog_sleep               <= 1'b0;
            active_profile             <= 2'b00;
            profile_out                <= '0;
            prdata                     <= 32'h0;
            pready                     <= 1'b0;
            pslverr                    <= 1'b0;
        end
        else
        begin
            pll_lock_out   <= lock_s2_reg;
            pll_enable     <= (mult != uhk_pkg::MULT_BYPASS) & ~ctrl1_reg[uhk_pkg::SLEEP_BIT];
            // out-of-range codes keep the previous factor; 200 MHz limit is the user's
            if (mult == uhk_pkg::MULT_BYPASS || (mult >= uhk_pkg::MULT_MIN && mult <= uhk_pkg::MULT_MAX))
                pll_multiplier <= mult;
            ref_diff_mode  <= diff_s2_reg;
            interpolator_overflow_flag <= ovf_next & ~in_hold & ~in_flush;
            parallel_data_clock_gate   <= ~in_hold;
            accum_clear    <= in_hold | ftw_zero;
            iq_force_zero  <= in_hold | in_flush;
            cic_reset      <= in_hold | in_flush;
            data_ignore    <= in_hold | in_flush;
            tx_gate_out    <= gate_s & ~in_hold;
            chain_clock_enable <= ~in_down;
            analog_sleep   <= in_down & ctrl1_reg[uhk_pkg::SLEEP_BIT];
            active_profile <= prof_sel_reg;
            profile_out.ftw            <= ftw_reg[prof_sel_reg];
            profile_out.spec_invert    <= cur_cfg[uhk_pkg::CFG_SPINV_BIT] & ~tone_s;
            profile_out.inv_cic_bypass <= cur_cfg[uhk_pkg::CFG_INVCIC_BIT];
            profile_out.cic_rate       <= eff_rate;
            profile_out.scale          <= cur_cfg[uhk_pkg::CFG_SCALE_LSB +: 8];
            // no wait state: ready registered at the edge ending setup, high in the first access cycle
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= apb_rd ? rd_mux : prdata;
        end
    end

    // ==========================================================
    // assertions
    property p_lock_follow;
        @(posedge pclk) disable iff (!presetn)
        $rose(lock_s2_reg) |=> pll_lock_out;
    endproperty
    a_lock_follow: assert property (p_lock_follow) else $error("lock out not following");

    property p_hold_zero;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == uhk_pkg::ST_HOLD) |-> iq_force_zero && cic_reset && !parallel_data_clock_gate
                                            && accum_clear && !tx_gate_out;
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("hold not forcing");

    property p_mon_off;
        @(posedge pclk) disable iff (!presetn)
        ctrl0_reg[uhk_pkg::LOCKMON_BIT] |=> state_reg != uhk_pkg::ST_HOLD;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("hold with monitor set");

    property p_clr_start;
        @(posedge pclk) disable iff (!presetn)
        (clr_write && !unlocked_hold) |=> state_reg == uhk_pkg::ST_FLUSH;
    endproperty
    a_clr_start: assert property (p_clr_start) else $error("flush not started");

    property p_selfclr;
        @(posedge pclk) disable iff (!presetn)
        (flush_done && !(apb_wr && hit_ctrl0)) |=> !ctrl0_reg[uhk_pkg::CICCLR_BIT];
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("clear bit stuck");

    property p_flush_cic;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == uhk_pkg::ST_FLUSH) |-> cic_reset && data_ignore;
    endproperty
    a_flush_cic: assert property (p_flush_cic) else $error("cic not held in flush");

    property p_down_parallel_data_clock;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == uhk_pkg::ST_DOWN) |-> parallel_data_clock_gate && !chain_clock_enable;
    endproperty
    a_down_parallel_data_clock: assert property (p_down_parallel_data_clock) else $error("powerdown outputs wrong");

    property p_down_via_flush;
        @(posedge pclk) disable iff (!presetn)
        $rose(state_reg == uhk_pkg::ST_DOWN) |-> $past(state_reg) == uhk_pkg::ST_FLUSH;
    endproperty
    a_down_via_flush: assert property (p_down_via_flush) else $error("powerdown skipped flush");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        (mult == uhk_pkg::MULT_BYPASS) |=> !pll_enable;
    endproperty
    a_bypass: assert property (p_bypass) else $error("pll on in bypass");

    c_flush: cover property (@(posedge pclk) disable iff (!presetn) flush_done);
    c_down:  cover property (@(posedge pclk) disable iff (!presetn) state_reg == uhk_pkg::ST_DOWN);
    c_hold:  cover property (@(posedge pclk) disable iff (!presetn) state_reg == uhk_pkg::ST_HOLD);

endmodule

// >>> tb/uhk_host_model.sv
// host controller model: drives the pin side of the housekeeping block
// assumes the bench calls set_pins just after a rising pclk edge
`timescale 1ns/1ps

module uhk_host_model (
    input  wire logic pclk,
    output logic      profile_select_low,
    output logic      profile_select_high,
    output logic      pll_lock_in,
    output logic      digital_powerdown_pin,
    output logic      burst_transmit_gate,
    output logic      differential_reference_select,
    output logic      cic_overflow_event,
    output logic      cic_msb_in,
    output logic      parallel_data_clock_tick,
    output logic      single_tone_mode
);
    logic [8:0] pins_reg = 9'h004;
    logic       tick_reg = 1'b0;

    // ==========================================================
    // pin levels
    // new levels land in the update region, never racing the edge
    task automatic set_pins(input logic [8:0] v);
        pins_reg <= v;
    endtask

    // data clock marker runs free, the device samples select on it
    always_ff @(posedge pclk)
        tick_reg <= ~tick_reg;

    // pin map; lock is only dropped for as long as a scenario asks
    assign {single_tone_mode, cic_msb_in, cic_overflow_event, differential_reference_select} = pins_reg[8:5];
    assign burst_transmit_gate   = pins_reg[4] & pins_reg[2];
    assign digital_powerdown_pin = pins_reg[3];
    assign pll_lock_in           = pins_reg[2];
    assign profile_select_high   = pins_reg[1];
    assign profile_select_low    = pins_reg[0];
    assign parallel_data_clock_tick            = tick_reg;
endmodule

// >>> tb/upconverter_housekeeping_control_bench.sv
// bench for the housekeeping block: apb register tasks plus pin scenarios
// assumes the host model drives every pin input
`timescale 1ns/1ps

module upconverter_housekeeping_control_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, profile_select_low, profile_select_high, pll_lock_in, digital_powerdown_pin;
    logic burst_transmit_gate, differential_reference_select, cic_overflow_event, cic_msb_in, parallel_data_clock_tick;
    logic single_tone_mode, pll_lock_out, pll_enable, ref_diff_mode, interpolator_overflow_flag;
    logic parallel_data_clock_gate, accum_clear, iq_force_zero, cic_reset, data_ignore, tx_gate_out;
    logic chain_clock_enable, analog_sleep;
    logic [4:0] pll_multiplier;
    logic [1:0] active_profile;
    uhk_pkg::uhk_profile_s profile_out;
    logic [8:0] pv = 9'h004;
    int n_errors = 0;
    int samples_checked = 0;
    int n;

    always #25 pclk = ~pclk;

    uhk_housekeeping dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .profile_select_low, .profile_select_high, .pll_lock_in, .digital_powerdown_pin,
        .burst_transmit_gate, .differential_reference_select, .cic_overflow_event, .cic_msb_in, .parallel_data_clock_tick,
        .single_tone_mode, .pll_lock_out, .pll_enable, .pll_multiplier, .ref_diff_mode,
        .interpolator_overflow_flag, .parallel_data_clock_gate, .accum_clear, .iq_force_zero, .cic_reset,
        .data_ignore, .tx_gate_out, .chain_clock_enable, .analog_sleep, .active_profile, .profile_out);
    uhk_host_model host_u (.pclk, .profile_select_low, .profile_select_high, .pll_lock_in,
        .digital_powerdown_pin, .burst_transmit_gate, .differential_reference_select, .cic_overflow_event,
        .cic_msb_in, .parallel_data_clock_tick, .single_tone_mode);

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                       input logic experr);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
        if (!w) chk(prdata, exp);
        chk({k < 20, pslverr}, {1'b1, experr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // pins change one at a time, an edge apart
    task automatic pin(input int b, input logic v);
        pv[b] = v;
        host_u.set_pins(pv);
        @(posedge pclk);
    endtask

    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (n = 0; n < 1000 && data_ignore === 1'b1; n++) @(posedge pclk);
        chk(n >= 100 && n < 1000, 1'b1);
        apb(0, 8'h00, 0, 32'h24, 0);
        apb(0, 8'h14, 0, 32'h1, 0);
        apb(0, 8'hfc, 0, 32'h0, 1);
        chk(accum_clear, 1'b1);
        apb(1, 8'h30, 32'h12345678, 0, 0);
        apb(1, 8'h34, 32'h8cc2, 0, 0);
        pin(1, 1'b1);
        idle(5);
        chk({active_profile, profile_out, accum_clear}, {2'd2, 32'h12345678, 2'b11, 6'h02, 8'h8c, 1'b0});
        apb(1, 8'h00, 32'h21, 0, 0);
        idle(3);
        chk(pll_enable, 1'b0);
        apb(1, 8'h00, 32'h34, 0, 0);
        apb(1, 8'h00, 32'h35, 0, 0);
        idle(3);
        chk({pll_enable, pll_multiplier}, 6'h34);
        // clear routine at rate 2 must outlast a rate 1 flush
        apb(1, 8'h00, 32'ha4, 0, 0);
        apb(0, 8'h00, 0, 32'ha4, 0);
        chk({data_ignore, cic_reset, iq_force_zero, pll_lock_out}, 4'hf);
        for (n = 0; n < 1000 && data_ignore === 1'b1; n++) @(posedge pclk);
        chk(n >= 200 && n <= 240, 1'b1);
        apb(0, 8'h00, 0, 32'h24, 0);
        apb(1, 8'h00, 32'h04, 0, 0);
        pin(4, 1'b1);
        idle(5);
        chk(tx_gate_out, 1'b1);
        pin(2, 1'b0);
        idle(5);
        chk({pll_lock_out, parallel_data_clock_gate, tx_gate_out, accum_clear, iq_force_zero, cic_reset}, 6'h07);
        pin(2, 1'b1);
        for (n = 0; n < 20 && parallel_data_clock_gate !== 1'b1; n++) @(posedge pclk);
        chk({n < 20, data_ignore}, 2'b11);
        for (n = 0; n < 1000 && data_ignore === 1'b1; n++) @(posedge pclk);
        chk({n < 1000, parallel_data_clock_gate}, 2'b11);
        apb(1, 8'h00, 32'h24, 0, 0);
        pin(2, 1'b0);
        idle(5);
        chk({pll_lock_out, data_ignore, parallel_data_clock_gate}, 3'b001);
        pin(2, 1'b1);
        pin(5, 1'b1);
        idle(5);
        chk(ref_diff_mode, 1'b1);
        pin(5, 1'b0);
        pin(6, 1'b1);
        pin(7, 1'b1);
        idle(5);
        chk({ref_diff_mode, interpolator_overflow_flag}, 2'b01);
        pin(7, 1'b0);
        idle(5);
        chk(interpolator_overflow_flag, 1'b0);
        pin(6, 1'b0);
        pin(3, 1'b1);
        for (n = 0; n < 1000 && chain_clock_enable !== 1'b0; n++) @(posedge pclk);
        chk({n >= 200, n < 1000, parallel_data_clock_gate}, 3'b111);
        pin(3, 1'b0);
        idle(5);
        chk(chain_clock_enable, 1'b1);
        apb(1, 8'h04, 32'h08, 0, 0);
        for (n = 0; n < 1000 && analog_sleep !== 1'b1; n++) @(posedge pclk);
        chk({n >= 200, n < 1000}, 2'b11);
        pin(8, 1'b1);
        idle(5);
        chk(profile_out.spec_invert, 1'b0);
        apb(0, 8'h00, 0, 32'h24, 0);
        apb(0, 8'h04, 0, 32'h08, 0);
        end_of_test();
    end

    // hang guard: the scenarios need well under two thousand cycles
    initial
    begin
        #(50 * 20000);
        n_errors++;
        end_of_test();
    end
endmodule
